// ==== rtl/tdm_rx_pkg.sv ====
package tdm_rx_pkg;

    // ==================================================================
    // Register map (byte addresses on the bus)
    // ==================================================================
    localparam logic [15:0] ADR_CHAN_COUNT   = 16'ha800;
    localparam logic [15:0] ADR_PTR_ENABLES  = 16'ha804;
    localparam logic [15:0] ADR_MAP_LOW      = 16'ha808;
    localparam logic [15:0] ADR_MAP_HIGH     = 16'ha80c;
    localparam logic [15:0] ADR_FRAME_LOW    = 16'ha820;
    localparam logic [15:0] ADR_FRAME_HIGH   = 16'ha824;
    localparam logic [15:0] ADR_STATUS       = 16'ha828;

    // ==================================================================
    // Field layout
    // ==================================================================
    localparam int          LANES            = 4;
    localparam int          PTR_W            = 5;
    localparam int          LANE_STRIDE      = 8;
    localparam int          SLOT_W           = 6;
    localparam int          ENABLE_LSB       = 16;
    localparam int          ENABLE_HIGH_LSB  = 20;
    localparam int          STAT_AVAIL_BIT   = 0;
    localparam int          STAT_OVERRUN_BIT = 1;
    localparam int          STAT_SLOT_LSB    = 8;
    localparam logic [31:0] PTR_FIELD_MASK   = 32'h1f1f_1f1f;

    // ==================================================================
    // Reset values and FIFO shape
    // ==================================================================
    localparam logic [31:0] MAP_RESET        = 32'h0000_0000;
    localparam logic [7:0]  ENABLE_RESET     = 8'h00;
    localparam logic [4:0]  CHAN_RESET       = 5'h00;
    localparam logic [5:0]  SLOT_MAX         = 6'h3f;
    localparam logic [2:0]  BIT_LAST         = 3'h7;
    localparam int          FRAME_W          = 64;
    localparam int          FIFO_DEPTH       = 4;

endpackage

// ==== rtl/frame_fifo_if.sv ====
`timescale 1ns/1ps

interface frame_fifo_if #(
    parameter int WIDTH = 64
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport source (output push_valid, output push_data, input push_ready,
                    input pop_valid, input pop_data, output pop_ready);
    modport store  (input push_valid, input push_data, output push_ready,
                    output pop_valid, output pop_data, input pop_ready);
endinterface

// ==== rtl/frame_fifo.sv ====
`timescale 1ns/1ps

module frame_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    frame_fifo_if.store fifo
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full;
    wire              empty;
    wire              do_push;
    wire              do_pop;

    // One spare pointer bit tells full from empty without a counter.
    assign full            = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign empty           = (wr_ptr == rd_ptr);
    assign do_push         = fifo.push_valid && !full;
    assign do_pop          = fifo.pop_ready && !empty;
    assign fifo.push_ready = !full;
    assign fifo.pop_valid  = !empty;
    assign fifo.pop_data   = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= fifo.push_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(do_push);
            rd_ptr <= rd_ptr + (AW+1)'(do_pop);
        end
    end
endmodule // frame_fifo

// ==== rtl/tdm_rx_timeslot_map.sv ====
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps

// ======================================================================
// Overview of operation
// - Four 5-bit low-set lane pointers at bits 4:0, 12:8, 20:16, 28:24.
// - Low set and its pointers serve slots zero through the channel count.
// - High set serves slots channel count plus one to twice count plus one.
// - Low-set pointer fields reset to zero and read back what was written.
// - High-set pointer fields reset to zero and are write-only.
// - A pointer acts only while its enable bit, bits 16 to 23, is set.
// ======================================================================

module tdm_rx_timeslot_map (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        hw_bit_clk_i,
    input  wire logic        hw_frame_sync_i,
    input  wire logic        hw_data_i
);

    // ==================================================================
    // Highway pin synchronisers
    // ==================================================================
    logic [1:0] clk_sync;
    logic [1:0] fsync_sync;
    logic [1:0] data_sync;
    logic       clk_last;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sync   <= '0;
            fsync_sync <= '0;
            data_sync  <= '0;
            clk_last   <= 1'b0;
        end else begin
            clk_sync   <= {clk_sync[0], hw_bit_clk_i};
            fsync_sync <= {fsync_sync[0], hw_frame_sync_i};
            data_sync  <= {data_sync[0], hw_data_i};
            clk_last   <= clk_sync[1];
        end
    end

    wire bit_edge  = clk_sync[1] && !clk_last;
    wire bit_val   = data_sync[1];
    wire frame_mark = bit_edge && fsync_sync[1];

    // ==================================================================
    // Slot deserialiser
    // ==================================================================
    // Bits arrive most significant first; a frame mark on a bit edge is
    // bit 7 of slot 0.  The slot counter saturates so that a missing
    // frame mark cannot wrap back onto low slots.
    logic [6:0]               shift;
    logic [2:0]               bit_cnt;
    logic [tdm_rx_pkg::SLOT_W-1:0] slot;
    logic                     byte_done;
    logic [7:0]               byte_val;
    logic [tdm_rx_pkg::SLOT_W-1:0] byte_slot;
    logic                     frame_seen;

    wire [2:0] next_bit_cnt = frame_mark ? 3'h1 : bit_cnt + 3'h1;
    wire       byte_end     = bit_edge && !frame_mark && (bit_cnt == tdm_rx_pkg::BIT_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift     <= '0;
            bit_cnt   <= '0;
            slot      <= '0;
            byte_done <= 1'b0;
            byte_val  <= '0;
            byte_slot <= '0;
        end else begin
            byte_done <= byte_end;
            if (bit_edge) begin
                shift   <= {shift[5:0], bit_val};
                bit_cnt <= next_bit_cnt;
            end
            if (frame_mark) begin
                slot <= '0;
            end else if (byte_end) begin
                byte_val  <= {shift, bit_val};
                byte_slot <= slot;
                if (slot != tdm_rx_pkg::SLOT_MAX) begin
                    slot <= slot + 1'b1;
                end
            end
        end
    end

    // ==================================================================
    // Registers
    // ==================================================================
    logic [31:0] map_low;
    logic [31:0] map_high;
    logic [7:0]  ptr_enables;
    logic [4:0]  chan_count;
    logic        overrun;
    logic [31:0] hold_low;
    logic [31:0] hold_high;

    function automatic logic [tdm_rx_pkg::PTR_W-1:0] lane_ptr(input logic [31:0] word,
                                                          input int lane);
        lane_ptr = word[lane*tdm_rx_pkg::LANE_STRIDE +: tdm_rx_pkg::PTR_W];
    endfunction

    function automatic logic [31:0] merge_sel(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge_sel[b*8 +: 8] = sel[b] ? new_val[b*8 +: 8] : old_val[b*8 +: 8];
        end
    endfunction

    // Limits of each set; six bits hold twice a five-bit count plus one.
    wire [tdm_rx_pkg::SLOT_W-1:0] low_last   = {1'b0, chan_count};
    wire [tdm_rx_pkg::SLOT_W-1:0] high_base  = {1'b0, chan_count} + 6'h01;
    wire [tdm_rx_pkg::SLOT_W-1:0] high_last  = {chan_count, 1'b1};

    // ==================================================================
    // Lane capture
    // ==================================================================
    logic [3:0] low_hit;
    logic [3:0] high_hit;

    genvar g;
    generate
        for (g = 0; g < tdm_rx_pkg::LANES; g++) begin : g_lane
            wire [tdm_rx_pkg::SLOT_W-1:0] high_target =
                {1'b0, lane_ptr(map_high, g)} + high_base;
            assign low_hit[g]  = byte_done
                && ptr_enables[g]
                && (byte_slot == {1'b0, lane_ptr(map_low, g)})
                && (byte_slot <= low_last);
            assign high_hit[g] = byte_done
                && ptr_enables[tdm_rx_pkg::ENABLE_HIGH_LSB - tdm_rx_pkg::ENABLE_LSB + g]
                && (byte_slot == high_target)
                && (byte_slot <= high_last);

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    hold_low[g*8 +: 8]  <= '0;
                    hold_high[g*8 +: 8] <= '0;
                end else begin
                    if (low_hit[g]) begin
                        hold_low[g*8 +: 8] <= byte_val;
                    end
                    if (high_hit[g]) begin
                        hold_high[g*8 +: 8] <= byte_val;
                    end
                end
            end
        end
    endgenerate

    // ==================================================================
    // Frame FIFO
    // ==================================================================
    // Each completed frame hands both holding words over as one entry.
    // A frame that finds the FIFO full is dropped and flagged, since the
    // highway cannot be stalled.
    frame_fifo_if #(.WIDTH(tdm_rx_pkg::FRAME_W)) frames ();

    frame_fifo #(
        .WIDTH (tdm_rx_pkg::FRAME_W),
        .DEPTH (tdm_rx_pkg::FIFO_DEPTH)
    ) u_frame_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .fifo  (frames.store)
    );

    wire frame_push = frame_mark && frame_seen;
    assign frames.push_valid = frame_push;
    assign frames.push_data  = {hold_high, hold_low};
    wire frame_lost = frame_push && !frames.push_ready;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_seen <= 1'b0;
        end else if (frame_mark) begin
            frame_seen <= 1'b1;
        end
    end

    // ==================================================================
    // Wishbone slave
    // ==================================================================
    // Ack comes one cycle after the request; writes and pops happen on
    // the edge where the master sees ack, so each access acts once.
    wire       bus_req   = wb_cyc_i && wb_stb_i;
    wire       bus_done  = bus_req && wb_ack_o;
    wire       bus_wr    = bus_done && wb_we_i;
    wire       bus_rd    = bus_done && !wb_we_i;
    wire [13:0] word_adr = wb_adr_i[15:2];

    wire hit_chan   = (word_adr == tdm_rx_pkg::ADR_CHAN_COUNT[15:2]);
    wire hit_enable = (word_adr == tdm_rx_pkg::ADR_PTR_ENABLES[15:2]);
    wire hit_low    = (word_adr == tdm_rx_pkg::ADR_MAP_LOW[15:2]);
    wire hit_high   = (word_adr == tdm_rx_pkg::ADR_MAP_HIGH[15:2]);
    wire hit_flow   = (word_adr == tdm_rx_pkg::ADR_FRAME_LOW[15:2]);
    wire hit_fhigh  = (word_adr == tdm_rx_pkg::ADR_FRAME_HIGH[15:2]);
    wire hit_status = (word_adr == tdm_rx_pkg::ADR_STATUS[15:2]);

    assign frames.pop_ready = bus_rd && hit_fhigh;

    wire [31:0] enable_word = {8'h00, ptr_enables, 16'h0000};
    wire [31:0] status_word = {18'h0_0000, slot, 6'h00, overrun, frames.pop_valid};
    wire [31:0] frame_head_low  = frames.pop_data[31:0];
    wire [31:0] frame_head_high = frames.pop_data[63:32];

    wire [31:0] read_mux =
          hit_chan   ? {27'h000_0000, chan_count}
        : hit_enable ? enable_word
        : hit_low    ? map_low
        : hit_high   ? 32'h0000_0000
        : hit_flow   ? frame_head_low
        : hit_fhigh  ? frame_head_high
        : hit_status ? status_word
        : 32'h0000_0000;

    wire [31:0] merged_low    = merge_sel(map_low, wb_dat_i, wb_sel_i);
    wire [31:0] merged_high   = merge_sel(map_high, wb_dat_i, wb_sel_i);
    wire [31:0] merged_enable = merge_sel(enable_word, wb_dat_i, wb_sel_i);
    wire        overrun_clear = bus_wr && hit_status && wb_sel_i[0]
                                && wb_dat_i[tdm_rx_pkg::STAT_OVERRUN_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= (bus_req && !wb_ack_o && !wb_we_i) ? read_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_low     <= tdm_rx_pkg::MAP_RESET;
            map_high    <= tdm_rx_pkg::MAP_RESET;
            ptr_enables <= tdm_rx_pkg::ENABLE_RESET;
            chan_count  <= tdm_rx_pkg::CHAN_RESET;
        end else if (bus_wr) begin
            if (hit_low) begin
                map_low <= merged_low & tdm_rx_pkg::PTR_FIELD_MASK;
            end
            if (hit_high) begin
                map_high <= merged_high & tdm_rx_pkg::PTR_FIELD_MASK;
            end
            if (hit_enable) begin
                ptr_enables <= merged_enable[tdm_rx_pkg::ENABLE_LSB +: 8];
            end
            if (hit_chan && wb_sel_i[0]) begin
                chan_count <= wb_dat_i[4:0];
            end
        end
    end

    // A lost frame in the same cycle as a clear keeps the flag set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
        end else if (frame_lost) begin
            overrun <= 1'b1;
        end else if (overrun_clear) begin
            overrun <= 1'b0;
        end
    end

endmodule // tdm_rx_timeslot_map

// ==== tb/tdm_rx_map_checker.sv ====
`timescale 1ns/1ps

// ======================================================================
// Bus-side checker
// ======================================================================
module tdm_rx_map_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [31:0] low_shadow;
    wire         take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire  [15:0] wadr     = {wb_adr_i[15:2], 2'b00};
    wire  [31:0] bytes    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire  [31:0] next_low = (low_shadow & ~bytes)
                          | (wb_dat_i & bytes & tdm_rx_pkg::PTR_FIELD_MASK);
    wire         rd_low   = take && !wb_we_i && wadr == tdm_rx_pkg::ADR_MAP_LOW;
    wire         rd_high  = take && !wb_we_i && wadr == tdm_rx_pkg::ADR_MAP_HIGH;
    wire         rd_en    = take && !wb_we_i && wadr == tdm_rx_pkg::ADR_PTR_ENABLES;

    // The shadow follows byte enables so a partial write cannot hide a lane slip.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_shadow <= tdm_rx_pkg::MAP_RESET;
        end else if (take && wb_we_i && wadr == tdm_rx_pkg::ADR_MAP_LOW) begin
            low_shadow <= next_low;
        end
    end

    property p_ack_next;     take |=> wb_ack_o; endproperty
    property p_ack_pulse;    wb_ack_o |=> !wb_ack_o; endproperty
    property p_idle_quiet;   !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    property p_dat_idle;     !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    property p_low_readback; rd_low |=> wb_ack_o && wb_dat_o == low_shadow; endproperty
    property p_low_fields;   rd_low |=> (wb_dat_o & ~tdm_rx_pkg::PTR_FIELD_MASK) == 0; endproperty
    property p_high_hidden;  rd_high |=> wb_ack_o && wb_dat_o == 32'h0000_0000; endproperty
    property p_en_fields;    rd_en |=> wb_dat_o[15:0] == 0 && wb_dat_o[31:24] == 0; endproperty

    a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_idle_quiet: assert property (p_idle_quiet) else $error("ack without request");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_low_readback: assert property (p_low_readback) else $error("low map readback");
    a_low_fields: assert property (p_low_fields) else $error("low map reserved bits");
    a_high_hidden: assert property (p_high_hidden) else $error("high map readable");
    a_en_fields: assert property (p_en_fields) else $error("enable reserved bits");

    c_low_write: cover property (take && wb_we_i && wadr == tdm_rx_pkg::ADR_MAP_LOW);
    c_high_read: cover property (rd_high);
    c_data_ack:  cover property (wb_ack_o && wb_dat_o != 0);
endmodule // tdm_rx_map_checker

bind tdm_rx_timeslot_map tdm_rx_map_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ==== tb/tdm_highway_model.sv ====
`timescale 1ns/1ps

// ======================================================================
// Highway far side: bit clock only runs inside a frame
// ======================================================================
module tdm_highway_model #(
    parameter int SLOTS = 8,
    parameter int HALF  = 4
) (
    input  wire logic clk_i,
    output logic      bit_clk_o,
    output logic      frame_sync_o,
    output logic      data_o
);
    logic busy;

    initial begin
        bit_clk_o = 1'b0;
        frame_sync_o = 1'b0;
        data_o = 1'b0;
        busy = 1'b0;
    end

    // A released line toggles so a stale sample never looks like valid data.
    always @(posedge clk_i) begin
        if (!busy) data_o <= ~data_o;
    end

    task automatic send_frame(input logic [8*SLOTS-1:0] slot_bytes);
        busy = 1'b1;
        for (int s = 0; s < SLOTS; s++) begin
            for (int b = 7; b >= 0; b--) begin
                @(posedge clk_i);
                data_o <= slot_bytes[8*s+b];
                frame_sync_o <= (s == 0 && b == 7);
                repeat (HALF) @(posedge clk_i);
                bit_clk_o <= 1'b1;
                repeat (HALF) @(posedge clk_i);
                bit_clk_o <= 1'b0;
            end
        end
        @(posedge clk_i);
        frame_sync_o <= 1'b0;
        busy = 1'b0;
    endtask
endmodule // tdm_highway_model

// ==== tb/tdm_rx_timeslot_map_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) fail_note(g, e); end

// ======================================================================
// Testbench
// ======================================================================
module tdm_rx_timeslot_map_tb;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [15:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat, wb_rdat, q;
    logic        hw_clk, hw_sync, hw_dat;
    int          errors, checks_done;

    tdm_rx_timeslot_map dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .hw_bit_clk_i(hw_clk), .hw_frame_sync_i(hw_sync),
        .hw_data_i(hw_dat));

    tdm_highway_model model (.clk_i(clk_i), .bit_clk_o(hw_clk), .frame_sync_o(hw_sync),
        .data_o(hw_dat));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic fail_note(input logic [31:0] g, input logic [31:0] e);
        errors++;
        $display("[FAIL] %0t got %h expected %h", $time, g, e);
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= 4'hf;
        wb_adr <= a;
        wb_wdat <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) fail_note(32'h0000_0000, 32'h0000_0001);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [15:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic t_reset_values;
        rd(tdm_rx_pkg::ADR_MAP_LOW);
        `CHK(q, tdm_rx_pkg::MAP_RESET)
        rd(tdm_rx_pkg::ADR_MAP_HIGH);
        `CHK(q, 32'h0000_0000)
        rd(tdm_rx_pkg::ADR_PTR_ENABLES);
        `CHK(q, 32'h0000_0000)
        rd(16'ha830);
        `CHK(q, 32'h0000_0000)
    endtask

    task automatic t_register_access;
        wr(tdm_rx_pkg::ADR_MAP_LOW, 32'hffff_ffff);
        rd(tdm_rx_pkg::ADR_MAP_LOW);
        `CHK(q, 32'h1f1f_1f1f)
        wr(tdm_rx_pkg::ADR_MAP_HIGH, 32'h1f1f_1f1f);
        rd(tdm_rx_pkg::ADR_MAP_HIGH);
        `CHK(q, 32'h0000_0000)
        wr(tdm_rx_pkg::ADR_PTR_ENABLES, 32'hffff_ffff);
        rd(tdm_rx_pkg::ADR_PTR_ENABLES);
        `CHK(q, 32'h00ff_0000)
    endtask

    // Channel count 3: low set covers slots 0..3, high set 4..7.
    task automatic t_capture;
        wr(tdm_rx_pkg::ADR_CHAN_COUNT, 32'h0000_0003);
        wr(tdm_rx_pkg::ADR_MAP_LOW, 32'h0103_0002);
        wr(tdm_rx_pkg::ADR_MAP_HIGH, 32'h0201_0300);
        repeat (2) model.send_frame(64'ha7a6_a5a4_a3a2_a1a0);
        rd(tdm_rx_pkg::ADR_FRAME_LOW);
        `CHK(q, 32'ha1a3_a0a2)
        rd(tdm_rx_pkg::ADR_FRAME_HIGH);
        `CHK(q, 32'ha6a5_a7a4)
    endtask

    // Lane 0 disabled and lane 1 aimed past the low range keep old bytes.
    task automatic t_enable_gate;
        wr(tdm_rx_pkg::ADR_PTR_ENABLES, 32'h00fe_0000);
        wr(tdm_rx_pkg::ADR_MAP_LOW, 32'h0103_0502);
        repeat (2) model.send_frame(64'hb7b6_b5b4_b3b2_b1b0);
        rd(tdm_rx_pkg::ADR_FRAME_HIGH);
        rd(tdm_rx_pkg::ADR_FRAME_LOW);
        `CHK(q, 32'hb1b3_a0a2)
        rd(tdm_rx_pkg::ADR_FRAME_HIGH);
        `CHK(q, 32'hb6b5_b7b4)
    endtask

    task automatic t_fifo_overrun;
        repeat (5) model.send_frame(64'hc7c6_c5c4_c3c2_c1c0);
        rd(tdm_rx_pkg::ADR_STATUS);
        `CHK(q[1:0], 2'b11)
        `CHK(q[13:8], 6'h08)
        wr(tdm_rx_pkg::ADR_STATUS, 32'h0000_0002);
        rd(tdm_rx_pkg::ADR_STATUS);
        `CHK(q[1:0], 2'b01)
        repeat (4) rd(tdm_rx_pkg::ADR_FRAME_HIGH);
        rd(tdm_rx_pkg::ADR_STATUS);
        `CHK(q[0], 1'b0)
    endtask

    // Channel count 2: low set covers slots 0..2, high set 3..5, so a
    // high pointer of 3 aims at slot 6 and must be ignored.
    task automatic t_high_range;
        wr(tdm_rx_pkg::ADR_CHAN_COUNT, 32'h0000_0002);
        wr(tdm_rx_pkg::ADR_MAP_HIGH, 32'h0102_0003);
        repeat (2) model.send_frame(64'hd7d6_d5d4_d3d2_d1d0);
        rd(tdm_rx_pkg::ADR_FRAME_HIGH);
        rd(tdm_rx_pkg::ADR_FRAME_LOW);
        `CHK(q, 32'hd1c3_a0a2)
        rd(tdm_rx_pkg::ADR_FRAME_HIGH);
        `CHK(q, 32'hd4d5_d3c4)
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        summarize;
    end

    initial begin
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 16'h0000;
        wb_sel = 4'hf;
        wb_wdat = 32'h0000_0000;
        errors = 0;
        checks_done = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_values;
        t_register_access;
        t_capture;
        t_enable_gate;
        t_fifo_overrun;
        t_high_range;
        summarize;
    end
endmodule // tdm_rx_timeslot_map_tb
